// [common/bax_defines.svh]
/*
 Constants for the bank address extension block: register offsets, field
 positions, reset values and address-map figures. Assumes inclusion by bare name.
*/
`ifndef BAX_DEFINES_SVH
`define BAX_DEFINES_SVH

`define BAX_OFF_CTRL      8'h00
`define BAX_OFF_EXT       8'h04
`define BAX_OFF_ADDR      8'h08
`define BAX_OFF_BUS       8'h0c
`define BAX_OFF_CS        8'h10
`define BAX_OFF_STATUS    8'h14
`define BAX_OFF_VEC       8'h18
`define BAX_OFF_REGS      8'h1c

`define BAX_RESET_VEC     24'h000000
`define BAX_GAP_LO        24'h080000
`define BAX_GAP_HI        24'hf7ffff
`define BAX_BANK_COUNT    5'h10
`define BAX_BANK_BYTES    20'h10000
`define BAX_SPACE_BYTES   21'h100000
`define BAX_NIB_LOW       4'h0
`define BAX_NIB_HIGH      4'hf
`define BAX_EXT_RESET     4'h0
`define BAX_WORD_RESET    16'h0000

`define BAX_CTRL_SRC_LSB  0
`define BAX_CTRL_GO_BIT   4
`define BAX_CTRL_COPY_LSB 8
`define BAX_CTRL_COPYEN   12
`define BAX_CTRL_EXC_BIT  16
`define BAX_CTRL_RET_BIT  17
`define BAX_CTRL_B_LSB    24

`define BAX_ST_BUSY_BIT   0
`define BAX_ST_INEXC_BIT  1
`define BAX_ST_HIT_BIT    2

`endif

// [common/bax_pkg.sv]
/*
 Types for the bank address extension block.
 Assumes the offsets and figures come from bax_defines.svh.
*/
package bax_pkg;

    typedef enum logic [2:0] {
        BAX_SRC_EXT   = 3'h0,
        BAX_SRC_IDX1  = 3'h1,
        BAX_SRC_IDX2  = 3'h2,
        BAX_SRC_IDX3  = 3'h3,
        BAX_SRC_STACK = 3'h4,
        BAX_SRC_PC    = 3'h5
    } bax_src_e;

    typedef enum logic [5:0] {
        BAX_IDLE    = 6'h01,
        BAX_RV0     = 6'h02,
        BAX_RV1     = 6'h04,
        BAX_RV2     = 6'h08,
        BAX_RV3     = 6'h10,
        BAX_RUN     = 6'h20
    } bax_state_e;

    typedef struct packed {
        logic [3:0] extended_access_ext_field;
        logic [3:0] first_index_ext_field;
        logic [3:0] second_index_ext_field;
        logic [3:0] third_index_ext_field;
        logic [3:0] stack_ext_field;
        logic [3:0] program_counter_ext_field;
    } bax_ext_s;

    typedef struct packed {
        logic [23:0] addr;
        logic        rd;
    } bax_boot_s;

endpackage

// [hdl/bax_core.sv]
/*
 Bank address extension core: extension fields, 24-bit bus address forming,
 reset-vector fetch, exception entry/return and a chip-select comparator,
 all reachable over an AHB-Lite slave.
 Assumes one AHB-Lite master, word transfers, boot memory answering the
 boot fetch port one cycle after boot_rd.
*/
`include "bax_defines.svh"
`timescale 1ns/100ps
module bax_core (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic [23:0] bus_addr,
    output logic cs_match,
    output logic boot_rd,
    output logic [23:0] boot_addr,
    input wire logic [15:0] boot_data,
    output logic cpu_ready
);

    bax_pkg::bax_ext_s ext_q, ext_d;
    bax_pkg::bax_state_e st_q, st_d;
    logic [15:0] pc_q, pc_d, sp_q, sp_d, third_index_register_q, third_index_register_d;
    logic [15:0] ret_pc_q, ret_pc_d;
    logic [3:0] ret_pc_ext_q, ret_pc_ext_d;
    logic in_exc_q, in_exc_d;
    logic [15:0] addr_q, addr_d;
    logic [2:0] src_q, src_d;
    logic [23:0] csbase_q, csbase_d;
    logic [7:0] vec_q, vec_d;
    logic exc_pend_q, exc_pend_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic wr_pend_q, wr_pend_d, rd_pend_q, rd_pend_d;
    logic [7:0] off_q, off_d;
    logic [3:0] sel_ext;
    logic [19:0] low20;
    logic [23:0] ld_addr;

    // Sign-like mirror of bit 19 keeps every produced address out of the gap
    function automatic logic [23:0] bax_mirror(input logic [19:0] a);
        bax_mirror = {{4{a[19]}}, a};
    endfunction

    always_comb begin
        case (bax_pkg::bax_src_e'(src_q))
            bax_pkg::BAX_SRC_EXT: sel_ext = ext_q.extended_access_ext_field;
            bax_pkg::BAX_SRC_IDX1: sel_ext = ext_q.first_index_ext_field;
            bax_pkg::BAX_SRC_IDX2: sel_ext = ext_q.second_index_ext_field;
            bax_pkg::BAX_SRC_IDX3: sel_ext = ext_q.third_index_ext_field;
            bax_pkg::BAX_SRC_STACK: sel_ext = ext_q.stack_ext_field;
            bax_pkg::BAX_SRC_PC: sel_ext = ext_q.program_counter_ext_field;
            default: sel_ext = `BAX_EXT_RESET;
        endcase
        low20 = {sel_ext, addr_q};
    end

    // Boot fetch address walks the four reset-vector words
    always_comb begin
        case (st_q)
            bax_pkg::BAX_RV0: ld_addr = `BAX_RESET_VEC;
            bax_pkg::BAX_RV1: ld_addr = `BAX_RESET_VEC + 24'h000002;
            bax_pkg::BAX_RV2: ld_addr = `BAX_RESET_VEC + 24'h000004;
            bax_pkg::BAX_RV3: ld_addr = `BAX_RESET_VEC + 24'h000006;
            default: ld_addr = bax_mirror({`BAX_NIB_LOW, 7'h00, vec_q, 1'b0});
        endcase
    end

    always_comb begin
        logic ctrl_wr;
        ctrl_wr = 1'b0;
        st_d = st_q;
        ext_d = ext_q;
        pc_d = pc_q;
        sp_d = sp_q;
        third_index_register_d = third_index_register_q;
        ret_pc_d = ret_pc_q;
        ret_pc_ext_d = ret_pc_ext_q;
        in_exc_d = in_exc_q;
        addr_d = addr_q;
        src_d = src_q;
        csbase_d = csbase_q;
        vec_d = vec_q;
        exc_pend_d = 1'b0;
        hrdata_d = hrdata_q;
        wr_pend_d = 1'b0;
        rd_pend_d = 1'b0;
        off_d = off_q;
        if (hsel && hready && htrans[1]) begin
            wr_pend_d = hwrite;
            rd_pend_d = !hwrite;
            off_d = haddr[7:0];
        end
        // Reset-vector fetch: one word per cycle, data arrives a cycle later
        case (st_q)
            bax_pkg::BAX_IDLE: st_d = bax_pkg::BAX_RV0;
            bax_pkg::BAX_RV0: st_d = bax_pkg::BAX_RV1;
            bax_pkg::BAX_RV1: begin
                st_d = bax_pkg::BAX_RV2;
                ext_d.third_index_ext_field = boot_data[11:8];
                ext_d.stack_ext_field = boot_data[7:4];
                ext_d.program_counter_ext_field = boot_data[3:0];
            end
            bax_pkg::BAX_RV2: begin
                st_d = bax_pkg::BAX_RV3;
                pc_d = boot_data;
            end
            bax_pkg::BAX_RV3: begin
                st_d = bax_pkg::BAX_RUN;
                sp_d = boot_data;
            end
            bax_pkg::BAX_RUN: begin
                if (!cpu_ready) begin
                    third_index_register_d = boot_data;
                end
                if (exc_pend_q) begin
                    pc_d = boot_data;
                    ext_d.program_counter_ext_field = `BAX_NIB_LOW;
                end
            end
            default: st_d = bax_pkg::BAX_IDLE;
        endcase
        if (wr_pend_q) begin
            case (off_q)
                `BAX_OFF_CTRL: begin
                    ctrl_wr = 1'b1;
                    src_d = hwdata[`BAX_CTRL_SRC_LSB +: 3];
                    if (hwdata[`BAX_CTRL_COPYEN]) begin
                        case (hwdata[`BAX_CTRL_COPY_LSB +: 3])
                            3'h0: ext_d.extended_access_ext_field = hwdata[`BAX_CTRL_B_LSB +: 4];
                            3'h1: ext_d.first_index_ext_field = hwdata[`BAX_CTRL_B_LSB +: 4];
                            3'h2: ext_d.second_index_ext_field = hwdata[`BAX_CTRL_B_LSB +: 4];
                            3'h3: ext_d.third_index_ext_field = hwdata[`BAX_CTRL_B_LSB +: 4];
                            3'h4: ext_d.stack_ext_field = hwdata[`BAX_CTRL_B_LSB +: 4];
                            default: ext_d = ext_d;
                        endcase
                    end
                end
                `BAX_OFF_ADDR: addr_d = hwdata[15:0];
                `BAX_OFF_CS: csbase_d = hwdata[23:0];
                `BAX_OFF_VEC: vec_d = hwdata[7:0];
                default: ctrl_wr = 1'b0;
            endcase
        end
        // Exception entry saves the return point; return restores it
        if (ctrl_wr && cpu_ready && hwdata[`BAX_CTRL_EXC_BIT] && !in_exc_q) begin
            ret_pc_d = pc_q;
            ret_pc_ext_d = ext_q.program_counter_ext_field;
            in_exc_d = 1'b1;
            exc_pend_d = 1'b1;
        end else if (ctrl_wr && hwdata[`BAX_CTRL_RET_BIT] && in_exc_q) begin
            pc_d = ret_pc_q;
            ext_d.program_counter_ext_field = ret_pc_ext_q;
            in_exc_d = 1'b0;
        end
        if (rd_pend_d) begin
            case (haddr[7:0])
                `BAX_OFF_CTRL: hrdata_d = {29'h0, src_q};
                `BAX_OFF_EXT: hrdata_d = {8'h00, ext_q};
                `BAX_OFF_ADDR: hrdata_d = {16'h0000, addr_q};
                `BAX_OFF_BUS: hrdata_d = {8'h00, bus_addr};
                `BAX_OFF_CS: hrdata_d = {8'h00, csbase_q};
                `BAX_OFF_STATUS: hrdata_d = {29'h0, cs_match, in_exc_q, !cpu_ready};
                `BAX_OFF_VEC: hrdata_d = {16'h0000, pc_q};
                `BAX_OFF_REGS: hrdata_d = {sp_q, third_index_register_q};
                default: hrdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= bax_pkg::BAX_IDLE;
            ext_q <= '0;
            pc_q <= `BAX_WORD_RESET;
            sp_q <= `BAX_WORD_RESET;
            third_index_register_q <= `BAX_WORD_RESET;
            ret_pc_q <= `BAX_WORD_RESET;
            ret_pc_ext_q <= `BAX_EXT_RESET;
            in_exc_q <= 1'b0;
            addr_q <= `BAX_WORD_RESET;
            src_q <= 3'h0;
            csbase_q <= 24'h000000;
            vec_q <= 8'h00;
            exc_pend_q <= 1'b0;
            hrdata_q <= 32'h00000000;
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            off_q <= 8'h00;
        end else begin
            st_q <= st_d;
            ext_q <= ext_d;
            pc_q <= pc_d;
            sp_q <= sp_d;
            third_index_register_q <= third_index_register_d;
            ret_pc_q <= ret_pc_d;
            ret_pc_ext_q <= ret_pc_ext_d;
            in_exc_q <= in_exc_d;
            addr_q <= addr_d;
            src_q <= src_d;
            csbase_q <= csbase_d;
            vec_q <= vec_d;
            exc_pend_q <= exc_pend_d;
            hrdata_q <= hrdata_d;
            wr_pend_q <= wr_pend_d;
            rd_pend_q <= rd_pend_d;
            off_q <= off_d;
        end
    end

    // Fourth vector word lands in the first run cycle, so ready waits one more
    logic rdy_q;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rdy_q <= 1'b0;
        end else begin
            rdy_q <= (st_q == bax_pkg::BAX_RUN);
        end
    end

    assign cpu_ready = rdy_q;
    assign bus_addr = bax_mirror(low20);
    // Full 24-bit compare; a gap base can never equal a mirrored address
    assign cs_match = (bus_addr == csbase_q);
    assign boot_rd = (st_q != bax_pkg::BAX_IDLE) && !cpu_ready || exc_pend_d;
    assign boot_addr = ld_addr;
    assign hrdata = hrdata_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

endmodule // bax_core

// [tb/bax_boot_mem.sv]
/*
 Boot memory model on the core's fetch port: reset vector and a few handlers.
 Answers one cycle after a fetch; between fetches its data lines wander.
*/
`timescale 1ns/100ps
module bax_boot_mem (
    input wire logic ref_clk,
    input wire logic boot_rd,
    input wire logic [23:0] boot_addr,
    output logic [15:0] boot_data
);
    // One combined space only; a split space would need function-code decoding
    function automatic logic [15:0] word_at(input logic [23:0] a);
        case (a)
            24'h000000: return 16'h0a57;
            24'h000002: return 16'h0200;
            24'h000004: return 16'h3000;
            24'h000006: return 16'h1234;
            24'h00002e: return 16'h4444;
            24'h000030: return 16'h5555;
            default: return ~a[15:0];
        endcase
    endfunction
    initial boot_data = 16'h0000;
    // Inverting when idle keeps a stale word from passing for a good one
    always @(posedge ref_clk) begin
        if (boot_rd) boot_data <= word_at(boot_addr);
        else boot_data <= ~boot_data;
    end
endmodule // bax_boot_mem

// [tb/bax_core_sva.sv]
/*
 Checker for bax_core: bus address forming, boot fetches and the compare flag.
 Sees only the core's ports; bound at the foot of this file.
*/
`include "bax_defines.svh"
`timescale 1ns/100ps
module bax_core_chk (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [23:0] bus_addr,
    input wire logic cs_match,
    input wire logic boot_rd,
    input wire logic [23:0] boot_addr,
    input wire logic cpu_ready
);
    logic pend_q;
    logic [7:0] off_q;
    logic [2:0] src_q;
    logic [3:0] ext_q;
    logic [15:0] addr_q;
    logic [23:0] cs_q;
    logic [2:0] fetch_q;
    // Shadow of the writes, applied at the end of the data phase like the core
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pend_q <= 1'b0;
            off_q <= 8'h00;
            src_q <= 3'h0;
            ext_q <= 4'h0;
            addr_q <= 16'h0000;
            cs_q <= 24'h000000;
            fetch_q <= 3'h0;
        end else begin
            pend_q <= hsel && hready && htrans[1] && hwrite;
            off_q <= haddr[7:0];
            if (pend_q && off_q == `BAX_OFF_CTRL) begin
                src_q <= hwdata[2:0];
                if (hwdata[12] && hwdata[10:8] == 3'h0) ext_q <= hwdata[27:24];
            end
            if (pend_q && off_q == `BAX_OFF_ADDR) addr_q <= hwdata[15:0];
            if (pend_q && off_q == `BAX_OFF_CS) cs_q <= hwdata[23:0];
            // Saturates so later exception fetches do not wrap it
            if (boot_rd && fetch_q < 3'h4) fetch_q <= fetch_q + 3'h1;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    a_top_mirror: assert property (
        bus_addr[23:20] == {4{bus_addr[19]}}) else $error("Top address bits differ from bit 19");
    a_bank_nibble: assert property (
        bus_addr[23:20] == (bus_addr[19] ? `BAX_NIB_HIGH : `BAX_NIB_LOW)) else $error("Wrong top nibble");
    a_gap_never: assert property (
        !(bus_addr >= `BAX_GAP_LO && bus_addr <= `BAX_GAP_HI)) else $error("Address inside the gap");
    a_ext_concat: assert property (
        src_q == 3'h0 |-> bus_addr[19:0] == {ext_q, addr_q}) else $error("Extended address badly formed");
    a_cs_compare: assert property (
        cs_match == (bus_addr == cs_q)) else $error("Compare flag wrong");
    a_vec_bank0: assert property (
        boot_rd |-> boot_addr[23:9] == 15'h0000 && !boot_addr[0]) else $error("Fetch outside vector table");
    a_boot_start: assert property (
        $rose(reset_n) |-> ##[1:3] (boot_rd && boot_addr == `BAX_RESET_VEC)) else $error("No reset vector fetch");
    a_ready_late: assert property (
        $rose(cpu_ready) |-> fetch_q == 3'h4) else $error("Ready before four vector words");
    a_bus_okay: assert property (
        hreadyout && !hresp) else $error("Bus answer not ready and okay");
    c_hit: cover property (cs_match && bus_addr[19]);
    c_high_bank: cover property (bus_addr[19]);
    c_exc_fetch: cover property (boot_rd && cpu_ready);
endmodule // bax_core_chk
bind bax_core bax_core_chk u_chk (.ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hresp(hresp), .bus_addr(bus_addr), .cs_match(cs_match), .boot_rd(boot_rd),
    .boot_addr(boot_addr), .cpu_ready(cpu_ready));

// [tb/bax_core_test.sv]
/*
 Testbench for bax_core: register tasks over AHB-Lite and checked sequences.
 Assumes a zero-wait slave and the boot memory model on the fetch port.
*/
`include "bax_defines.svh"
`timescale 1ns/100ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin err_total++; \
    $display("Error %0t: got %h expected %h", $time, (got), (exp)); end end
module bax_core_test;
    logic ref_clk = 1'b0, reset_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rdv;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hrdata;
    logic hreadyout, hresp, cs_match, boot_rd, cpu_ready;
    logic [23:0] bus_addr, boot_addr;
    logic [15:0] boot_data;
    int err_total = 0, tests_run = 0, cyc = 0;
    bax_core DUT (.ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .bus_addr(bus_addr), .cs_match(cs_match),
        .boot_rd(boot_rd), .boot_addr(boot_addr), .boot_data(boot_data), .cpu_ready(cpu_ready));
    bax_boot_mem u_mem (.ref_clk(ref_clk), .boot_rd(boot_rd), .boot_addr(boot_addr), .boot_data(boot_data));
    always #12.5 ref_clk = ~ref_clk;
    task automatic report_and_stop;
        if (err_total == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 6000) begin
            err_total++;
            report_and_stop;
        end
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, rdv);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0, rdv);
        `CHK(rdv, exp)
    endtask
    task automatic boot;
        reset_n <= 1'b0;
        repeat (16) @(posedge ref_clk);
        `CHK(cpu_ready, 1'b0)
        reset_n <= 1'b1;
        for (int i = 0; i < 60 && cpu_ready !== 1'b1; i++) @(posedge ref_clk);
        `CHK(cpu_ready, 1'b1)
        rd_chk(`BAX_OFF_EXT, 32'h00000a57);
        rd_chk(`BAX_OFF_VEC, 32'h00000200);
        rd_chk(`BAX_OFF_REGS, 32'h30001234);
    endtask
    task automatic wait_idle;
        for (int i = 0; i < 20; i++) begin
            xfer(1'b0, `BAX_OFF_STATUS, 32'h0, rdv);
            if (rdv[`BAX_ST_BUSY_BIT] === 1'b0) break;
        end
        `CHK(rdv[`BAX_ST_BUSY_BIT], 1'b0)
    endtask
    initial begin
        boot();
        for (int t = 0; t < 5; t++) wr(`BAX_OFF_CTRL, {4'h0, 4'(t + 9), 11'h0, 1'b1, 1'b0, 3'(t), 8'h00});
        rd_chk(`BAX_OFF_EXT, 32'h009abcd7);
        wr(`BAX_OFF_ADDR, 32'h00008765);
        for (int s = 0; s < 5; s++) begin
            wr(`BAX_OFF_CTRL, {29'h0, 3'(s)});
            rd_chk(`BAX_OFF_BUS, {8'h00, 4'hf, 4'(s + 9), 16'h8765});
        end
        // Low and high banks from the extended-access field, top nibble follows bit 19
        for (int k = 0; k < 4; k++) begin
            wr(`BAX_OFF_CTRL, {4'h0, 4'(k * 4 + 3), 11'h0, 1'b1, 12'h000});
            rd_chk(`BAX_OFF_BUS, {8'h00, {4{k > 1}}, 4'(k * 4 + 3), 16'h8765});
        end
        wr(`BAX_OFF_CTRL, {4'h0, 4'h7, 11'h0, 1'b1, 12'h000});
        rd_chk(`BAX_OFF_BUS, 32'h00078765);
        wr(`BAX_OFF_CTRL, {4'h0, 4'h8, 11'h0, 1'b1, 12'h000});
        rd_chk(`BAX_OFF_BUS, 32'h00f88765);
        `CHK(bus_addr, 24'hf88765)
        wr(`BAX_OFF_CS, 32'h00f88765);
        rd_chk(`BAX_OFF_STATUS, 32'h00000004);
        `CHK(cs_match, 1'b1)
        wr(`BAX_OFF_CS, 32'h00088765);
        rd_chk(`BAX_OFF_STATUS, 32'h00000000);
        wr(`BAX_OFF_VEC, 32'h00000017);
        wr(`BAX_OFF_CTRL, 32'h00010000);
        wait_idle();
        rd_chk(`BAX_OFF_VEC, 32'h00004444);
        rd_chk(`BAX_OFF_EXT, 32'h008abcd0);
        wr(`BAX_OFF_VEC, 32'h00000018);
        wr(`BAX_OFF_CTRL, 32'h00010000);
        wait_idle();
        rd_chk(`BAX_OFF_VEC, 32'h00004444);
        rd_chk(`BAX_OFF_STATUS, 32'h00000002);
        wr(`BAX_OFF_CTRL, 32'h00020000);
        wait_idle();
        rd_chk(`BAX_OFF_VEC, 32'h00000200);
        rd_chk(`BAX_OFF_EXT, 32'h008abcd7);
        wr(8'h20, 32'hffffffff);
        rd_chk(8'h20, 32'h00000000);
        boot();
        report_and_stop;
    end
endmodule // bax_core_test
